// file: aer_regs.sv
// AER uncorrectable severity, correctable status and mask register bank
//
// How it works
// RQ1: Severity register at 10Ch, read-write, one bit fatal, zero non-fatal.
// RQ2: Severity resets fatal for bits 0,4,13,17,18; others non-fatal.
// RQ3: Receiver error sets correctable status bit 0.
// RQ4: Bad TLP received sets status bit 6.
// RQ5: Bad DLLP received sets status bit 7.
// RQ6: Replay number rollover sets status bit 8.
// RQ7: Replay timer expiry sets status bit 12.
// RQ8: Advisory non-fatal error sets status bit 13.
// RQ9: Status at 110h resets zero; write one clears, zero keeps.
// RQ10: Mask bits 0,6,7 suppress logging and messages of their errors.
// RQ11: Mask bits 8,12 suppress logging and messages for replay errors.
// RQ12: Mask bit 13 suppresses advisory errors and resets to one.
// RQ13: Mask at 114h read-write; bits 0,6,7,8,12 reset to zero.
// RQ14: Status bits set regardless of mask; mask gates reporting only.
// RQ15: Reserved bits read zero and ignore writes.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module aer_regs (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [aer_pkg::AER_AW-1:0] reg_addr,
	input wire logic [aer_pkg::AER_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [aer_pkg::AER_DW-1:0] reg_rdata,
	input wire logic evt_rx_err,
	input wire logic evt_bad_tlp,
	input wire logic evt_bad_dllp,
	input wire logic evt_replay_roll,
	input wire logic evt_replay_tmo,
	input wire logic evt_adv_nf,
	output logic [aer_pkg::AER_DW-1:0] unc_severity,
	output logic [aer_pkg::AER_DW-1:0] cor_report,
	output logic cor_msg_req,
	output logic irq
);
	import aer_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [AER_DW-1:0] sev_ff;
	logic [AER_DW-1:0] nxt_sev;
	logic [AER_DW-1:0] cmsk_ff;
	logic [AER_DW-1:0] nxt_cmsk;
	logic [AER_NIRQ-1:0] imsk_ff;
	logic [AER_NIRQ-1:0] nxt_imsk;
	logic [AER_DW-1:0] rdata_ff;
	logic [AER_DW-1:0] nxt_rdata;
	logic [AER_DW-1:0] report_ff;
	logic [AER_DW-1:0] nxt_report;
	logic msg_ff;
	logic nxt_msg;
	logic irq_ff;
	logic nxt_irq;

	logic [AER_DW-1:0] cor_evt;
	logic [AER_DW-1:0] cor_rpt;
	logic [AER_NIRQ-1:0] irq_evt;
	logic wr_sev;
	logic wr_csts;
	logic wr_cmsk;
	logic wr_ists;
	logic wr_imsk;

	aer_w1c_if #(.W(AER_DW)) csts_if ();
	aer_w1c_if #(.W(AER_NIRQ)) ists_if ();

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Write strobes per register; unmapped writes fall through unused
	always_comb begin
		wr_sev = 1'b0;
		wr_csts = 1'b0;
		wr_cmsk = 1'b0;
		wr_ists = 1'b0;
		wr_imsk = 1'b0;
		if (reg_wr && reg_addr == AER_OFS_SEV) begin
			wr_sev = 1'b1;
		end else if (reg_wr && reg_addr == AER_OFS_CSTS) begin
			wr_csts = 1'b1;
		end else if (reg_wr && reg_addr == AER_OFS_CMSK) begin
			wr_cmsk = 1'b1;
		end else if (reg_wr && reg_addr == AER_OFS_IRQ_STS) begin
			wr_ists = 1'b1;
		end else if (reg_wr && reg_addr == AER_OFS_IRQ_MSK) begin
			wr_imsk = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Correctable events
	// ----------------------------------------------------------------
	// Detection ignores the mask, so software can still poll masked errors
	always_comb begin
		cor_evt = AER_ZERO;
		cor_evt[AER_COR_RX_ERR] = evt_rx_err; // RQ3 RQ14
		cor_evt[AER_COR_BAD_TLP] = evt_bad_tlp; // RQ4
		cor_evt[AER_COR_BAD_DLLP] = evt_bad_dllp; // RQ5
		cor_evt[AER_COR_REPLAY_ROLL] = evt_replay_roll; // RQ6
		cor_evt[AER_COR_REPLAY_TMO] = evt_replay_tmo; // RQ7
		cor_evt[AER_COR_ADV_NF] = evt_adv_nf; // RQ8
		cor_rpt = cor_evt & ~cmsk_ff; // RQ10 RQ11 RQ12
	end

	// Status bank; clear only on a write to the status offset
	assign csts_if.set_evt = cor_evt;
	assign csts_if.clr_mask = wr_csts ? reg_wdata : AER_ZERO; // RQ9

	aer_w1c_bank #(.W(AER_DW), .IMPL(AER_COR_IMPL), .RST(AER_CSTS_RST)) u_csts (
		.core_clk(core_clk),
		.resetn(resetn),
		.bus(csts_if.owner)
	);

	// ----------------------------------------------------------------
	// Interrupt status
	// ----------------------------------------------------------------
	// One bit for any detection, one for any unmasked report
	always_comb begin
		irq_evt = '0;
		irq_evt[AER_IRQ_COR_SET] = |cor_evt;
		irq_evt[AER_IRQ_COR_RPT] = |cor_rpt;
	end

	assign ists_if.set_evt = irq_evt;
	assign ists_if.clr_mask = wr_ists ? reg_wdata[AER_NIRQ-1:0] : '0;

	aer_w1c_bank #(.W(AER_NIRQ), .IMPL('1), .RST('0)) u_ists (
		.core_clk(core_clk),
		.resetn(resetn),
		.bus(ists_if.owner)
	);

	// ----------------------------------------------------------------
	// Read-write registers
	// ----------------------------------------------------------------
	// Reserved bits are masked off so they never store anything
	always_comb begin
		nxt_sev = sev_ff;
		nxt_cmsk = cmsk_ff;
		nxt_imsk = imsk_ff;
		if (wr_sev) begin
			nxt_sev = reg_wdata & AER_SEV_IMPL; // RQ1 RQ15
		end
		if (wr_cmsk) begin
			nxt_cmsk = reg_wdata & AER_COR_IMPL; // RQ13 RQ15
		end
		if (wr_imsk) begin
			nxt_imsk = reg_wdata[AER_NIRQ-1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sev_ff <= AER_SEV_RST; // RQ2
			cmsk_ff <= AER_CMSK_RST; // RQ12 RQ13
			imsk_ff <= AER_IRQ_MSK_RST;
		end else begin
			sev_ff <= nxt_sev;
			cmsk_ff <= nxt_cmsk;
			imsk_ff <= nxt_imsk;
		end
	end

	// ----------------------------------------------------------------
	// Read data and outputs
	// ----------------------------------------------------------------
	// Read data valid only the cycle after the strobe; zero otherwise
	always_comb begin
		nxt_rdata = AER_ZERO;
		if (reg_rd) begin
			if (reg_addr == AER_OFS_SEV) begin
				nxt_rdata = sev_ff;
			end else if (reg_addr == AER_OFS_CSTS) begin
				nxt_rdata = csts_if.flags; // RQ15
			end else if (reg_addr == AER_OFS_CMSK) begin
				nxt_rdata = cmsk_ff;
			end else if (reg_addr == AER_OFS_IRQ_STS) begin
				nxt_rdata = {{(AER_DW-AER_NIRQ){1'b0}}, ists_if.flags};
			end else if (reg_addr == AER_OFS_IRQ_MSK) begin
				nxt_rdata = {{(AER_DW-AER_NIRQ){1'b0}}, imsk_ff};
			end
		end
		nxt_report = cor_rpt; // RQ10 RQ11
		nxt_msg = |cor_rpt; // RQ10 RQ11 RQ12
		// Irq lags status by a cycle; the trade is a registered output
		nxt_irq = |(ists_if.flags & imsk_ff);
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rdata_ff <= AER_ZERO;
			report_ff <= AER_ZERO;
			msg_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			report_ff <= nxt_report;
			msg_ff <= nxt_msg;
			irq_ff <= nxt_irq;
		end
	end

	assign reg_rdata = rdata_ff;
	assign unc_severity = sev_ff;
	assign cor_report = report_ff;
	assign cor_msg_req = msg_ff;
	assign irq = irq_ff;
endmodule : aer_regs
`default_nettype wire

// file: aer_pkg.sv
// Package for the AER severity, correctable status and mask register bank
package aer_pkg;
	localparam int AER_DW = 32;
	localparam int AER_AW = 12;
	// Register byte offsets
	localparam logic [11:0] AER_OFS_SEV = 12'h10C;
	localparam logic [11:0] AER_OFS_CSTS = 12'h110;
	localparam logic [11:0] AER_OFS_CMSK = 12'h114;
	localparam logic [11:0] AER_OFS_IRQ_STS = 12'h130;
	localparam logic [11:0] AER_OFS_IRQ_MSK = 12'h134;
	// Implemented bits and reset values
	localparam logic [31:0] AER_SEV_IMPL = 32'h003F_F011;
	localparam logic [31:0] AER_SEV_RST = 32'h0006_2011;
	localparam logic [31:0] AER_COR_IMPL = 32'h0000_31C1;
	localparam logic [31:0] AER_CSTS_RST = 32'h0000_0000;
	localparam logic [31:0] AER_CMSK_RST = 32'h0000_2000;
	localparam logic [31:0] AER_ZERO = 32'h0000_0000;
	// Correctable event bit positions
	localparam int AER_COR_RX_ERR = 0;
	localparam int AER_COR_BAD_TLP = 6;
	localparam int AER_COR_BAD_DLLP = 7;
	localparam int AER_COR_REPLAY_ROLL = 8;
	localparam int AER_COR_REPLAY_TMO = 12;
	localparam int AER_COR_ADV_NF = 13;
	// Interrupt status bits
	localparam int AER_NIRQ = 2;
	localparam int AER_IRQ_COR_SET = 0;
	localparam int AER_IRQ_COR_RPT = 1;
	localparam logic [1:0] AER_IRQ_MSK_RST = 2'h0;
endpackage : aer_pkg

// file: aer_w1c_if.sv
// Interface carrying one group of sticky write-one-to-clear flags
`timescale 1ns/100ps
`default_nettype none
interface aer_w1c_if #(parameter int W = 32);
	logic [W-1:0] set_evt;
	logic [W-1:0] clr_mask;
	logic [W-1:0] flags;
	modport owner (input set_evt, input clr_mask, output flags);
	modport user (output set_evt, output clr_mask, input flags);
endinterface : aer_w1c_if
`default_nettype wire

// file: aer_w1c_bank.sv
// Sticky flag bank: hardware set wins over software clear
`timescale 1ns/100ps
`default_nettype none
module aer_w1c_bank #(
	parameter int W = 32,
	parameter logic [W-1:0] IMPL = '1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic core_clk,
	input wire logic resetn,
	aer_w1c_if.owner bus
);
	logic [W-1:0] flags_ff;
	logic [W-1:0] nxt_flags;

	// Set beats clear so an event in the clearing cycle stays latched
	always_comb begin
		nxt_flags = ((flags_ff & ~bus.clr_mask) | bus.set_evt) & IMPL;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			flags_ff <= RST;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	assign bus.flags = flags_ff;
endmodule : aer_w1c_bank
`default_nettype wire

// file: aer_regs_checker.sv
// Port checker for the AER register bank
`timescale 1ns/100ps
`default_nettype none
module aer_regs_checker (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic reg_rd,
	input wire logic [aer_pkg::AER_DW-1:0] reg_rdata,
	input wire logic evt_rx_err,
	input wire logic evt_bad_tlp,
	input wire logic evt_bad_dllp,
	input wire logic evt_replay_roll,
	input wire logic evt_replay_tmo,
	input wire logic evt_adv_nf,
	input wire logic [aer_pkg::AER_DW-1:0] unc_severity,
	input wire logic [aer_pkg::AER_DW-1:0] cor_report,
	input wire logic cor_msg_req
);
	import aer_pkg::*;
	// One clock domain, so one default clock and reset
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	// A report bit needs its own event one cycle earlier
	chk_rx_cause: assert property (cor_report[0] |-> $past(evt_rx_err))
		else $error("rx report without event");
	chk_tlp_cause: assert property (cor_report[6] |-> $past(evt_bad_tlp))
		else $error("tlp report without event");
	chk_dllp_cause: assert property (cor_report[7] |-> $past(evt_bad_dllp))
		else $error("dllp report without event");
	chk_roll_cause: assert property (cor_report[8] |-> $past(evt_replay_roll))
		else $error("rollover report without event");
	chk_tmo_cause: assert property (cor_report[12] |-> $past(evt_replay_tmo))
		else $error("timeout report without event");
	chk_adv_cause: assert property (cor_report[13] |-> $past(evt_adv_nf))
		else $error("advisory report without event");
	chk_msg_follows: assert property (cor_msg_req == (|cor_report))
		else $error("message differs from reports");
	chk_sev_rsvd: assert property ((unc_severity & ~AER_SEV_IMPL) == AER_ZERO)
		else $error("reserved severity bit set");
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == AER_ZERO)
		else $error("read data outside read slot");
endmodule : aer_regs_checker
bind aer_regs aer_regs_checker chk_u (.core_clk, .resetn, .reg_rd, .reg_rdata,
	.evt_rx_err, .evt_bad_tlp, .evt_bad_dllp, .evt_replay_roll, .evt_replay_tmo,
	.evt_adv_nf, .unc_severity, .cor_report, .cor_msg_req);
`default_nettype wire

// file: aer_regs_tb.sv
// Self-checking bench for the AER register bank
`timescale 1ns/100ps
`default_nettype none
module aer_regs_tb;
	logic core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, msg, irq;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0, rdata, sev, rpt, m, d;
	logic [5:0] ev = 6'h00;
	int fails = 0, compares = 0, seed = 32'h073cb882, j;
	int pos[6] = '{0, 6, 7, 8, 12, 13};
	always #5 core_clk = ~core_clk;
	aer_regs dut_u (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
		.evt_rx_err(ev[0]), .evt_bad_tlp(ev[1]), .evt_bad_dllp(ev[2]),
		.evt_replay_roll(ev[3]), .evt_replay_tmo(ev[4]), .evt_adv_nf(ev[5]),
		.unc_severity(sev), .cor_report(rpt), .cor_msg_req(msg), .irq(irq));
	// Status bit that event number i should set
	function automatic logic [31:0] bitof(input int i);
		return 32'h1 << pos[i];
	endfunction : bitof
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rd
	task automatic pulse(input int i);
		@(posedge core_clk);
		ev <= 6'h01 << i;
		@(posedge core_clk);
		ev <= 6'h00;
		#1;
	endtask : pulse
	task automatic give_verdict();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	// Watchdog: the tests need well under a tenth of this span
	initial begin
		#100000;
		fails++;
		give_verdict();
	end
	initial begin
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		rd(12'h10C, 32'h0006_2011);
		rd(12'h110, 32'h0);
		rd(12'h114, 32'h0000_2000);
		chk(sev, 32'h0006_2011);
		$display("reset values done");
		// Random words first, then all ones and all zeros as corner cases
		for (int k = 0; k < 6; k++) begin
			d = (k == 4) ? 32'hFFFF_FFFF : (k == 5) ? 32'h0 : $random(seed);
			wr(12'h10C, d);
			rd(12'h10C, d & 32'h003F_F011);
			chk(sev, d & 32'h003F_F011);
			wr(12'h114, d);
			rd(12'h114, d & 32'h0000_31C1);
		end
		wr(12'h200, 32'hFFFF_FFFF);
		rd(12'h200, 32'h0);
		$display("read-write done");
		wr(12'h134, 32'h3);
		// First pass with the event unmasked, second pass masked
		for (int i = 0; i < 12; i++) begin
			j = i % 6;
			m = ($random(seed) & 32'h31C1 & ~bitof(j)) | (i > 5 ? bitof(j) : 32'h0);
			wr(12'h114, m);
			pulse(j);
			chk(rpt, bitof(j) & ~m);
			chk({31'h0, msg}, {31'h0, |(bitof(j) & ~m)});
			@(posedge core_clk);
			#1 chk({31'h0, irq}, 32'h1);
			rd(12'h110, bitof(j));
			wr(12'h110, 32'h0);
			rd(12'h110, bitof(j));
			wr(12'h110, bitof(j));
			rd(12'h110, 32'h0);
			wr(12'h130, 32'h3);
		end
		$display("events done");
		wr(12'h134, 32'h0);
		pulse(5);
		repeat (3) @(posedge core_clk);
		#1 chk({31'h0, irq}, 32'h0);
		$display("interrupt mask done");
		// Reset in mid-run must drop latched status and restore defaults
		pulse(0);
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		rd(12'h110, 32'h0);
		rd(12'h10C, 32'h0006_2011);
		rd(12'h114, 32'h0000_2000);
		chk(sev, 32'h0006_2011);
		$display("mid-run reset done");
		give_verdict();
	end
endmodule : aer_regs_tb
`default_nettype wire
